//--- src/smrl_top.sv
// Stop mode recovery logic with AXI4-Lite register access
// Functional notes
// - The recovery flag is set by hardware on each stop recovery and cleared only by power-on reset.
// - In the primary control register only the flag reads back; bits 6 to 2 and bit 0 are write only, bit 1 is not writable.
// - Primary bit 6 picks a low or high level needed at the XOR input from the chosen source.
// - Primary bit 5 picks the reset delay applied after a recovery.
// - Primary bits 4 to 2 pick the source allowed to end the stop state.
// - Primary bit 0 divides the system and timer clocks by sixteen when set.
// - Secondary codes 000 power-on only (default), 001 NAND port 2 pins 0-3, 010 NAND port 2 pins 0-7.
// - Codes 011/100 NOR/NAND port 3 pins 1-3, 101/110 add port 0 pins 0 and 7, 111 NAND with port 2 pins 0-2.
// - The secondary level bit needs low at 0, the default, and high at 1.
// - The secondary source field and level bit are write only.
// - With both registers in use either selected event ends the stop state.
// - Pins configured as outputs drop out of the NAND or NOR term.
// - The external reset pin never ends the stop state.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module smrl_top
  import smrl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] port2_pins,
  input wire logic [3:1] port3_pins,
  input wire logic port0_pin0,
  input wire logic port0_pin7,
  input wire logic [7:0] port2_is_out,
  input wire logic [3:1] port3_is_out,
  input wire logic port0_is_out,
  input wire logic ext_reset_n,
  output logic stop_active,
  output logic osc_restart,
  output logic sys_hold_reset,
  output logic clk_div16,
  output logic timer_clock_div16,
  output logic irq
);

  // Registered state
  smrl_state_t state_reg, state_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl2_reg;
  logic flag_reg;
  logic [1:0] int_stat_reg;
  logic [1:0] int_mask_reg;
  logic [7:0] dly_reg;
  logic [7:0] dly_next;
  logic [12:0] pin_s1_reg;
  logic [12:0] pin_s2_reg;
  logic rst_s1_reg;
  logic rst_s2_reg;
  logic [7:0] awaddr_reg;
  logic aw_full_reg;
  logic [7:0] wdata_reg;
  logic wstrb_reg;
  logic w_full_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Pin vectors in a common layout
  wire [12:0] pin_raw = {port0_pin7, port0_pin0, port3_pins, port2_pins};
  wire [12:0] pin_out = {port0_is_out, port0_is_out, port3_is_out, port2_is_out};

  // Wake test: term of the selected pins compared with the wanted level
  function automatic logic smrl_wake(input logic [2:0] src, input logic lvl,
                                     input logic [12:0] pins, input logic [12:0] outs);
    logic [12:0] m;
    logic term;
    begin
      m = 13'h0000;
      case (src)
        3'h1: m = SMRL_M_P2LO;
        3'h2: m = SMRL_M_P2;
        3'h3, 3'h4: m = SMRL_M_P3;
        3'h5, 3'h6: m = SMRL_M_P3P0;
        3'h7: m = SMRL_M_P3P2;
        default: m = 13'h0000;
      endcase
      m = m & ~outs;
      if (src == SMRL_SRC_NOR_P3 || src == SMRL_SRC_NOR_P3P0) begin
        term = ~|(pins & m);
      end else begin
        term = ~&(pins | ~m);
      end
      // Empty term, as with power-on only, never wakes
      smrl_wake = (|m) && (term == lvl);
    end
  endfunction

  // Field decode of both control registers
  wire [2:0] src1 = ctrl_reg[SMRL_SRC_LSB +: 3];
  wire [2:0] src2 = ctrl2_reg[SMRL_SRC_LSB +: 3];
  wire lvl1 = ctrl_reg[SMRL_BIT_LEVEL];
  wire lvl2 = ctrl2_reg[SMRL_BIT_LEVEL];
  wire wake1 = smrl_wake(src1, lvl1, pin_s2_reg, pin_out);
  wire wake2 = smrl_wake(src2, lvl2, pin_s2_reg, pin_out);
  wire wake_any = wake1 || wake2;
  // Clockless path on raw pins; the oscillator is off while stopped
  wire wake_raw = smrl_wake(src1, lvl1, pin_raw, pin_out) || smrl_wake(src2, lvl2, pin_raw, pin_out);
  wire in_stop = (state_reg == SMRL_STOP);
  wire ext_rst = !rst_s2_reg;

  // Bus decode
  wire [5:0] widx = awaddr_reg[7:2];
  wire [5:0] ridx = s_axi_araddr[7:2];
  wire wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  wire ar_fire = s_axi_arvalid && !rvalid_reg;
  wire wr_ctrl = wr_fire && wstrb_reg && (widx == SMRL_IDX_CTRL);
  wire wr_ctrl2 = wr_fire && wstrb_reg && (widx == SMRL_IDX_CTRL2);
  wire wr_mask = wr_fire && wstrb_reg && (widx == SMRL_IDX_INT_MASK);
  wire wr_stop = wr_fire && wstrb_reg && (widx == SMRL_IDX_STOP) && wdata_reg[0];
  wire w_hit = (widx == SMRL_IDX_CTRL) || (widx == SMRL_IDX_CTRL2) || (widx == SMRL_IDX_INT_STAT)
               || (widx == SMRL_IDX_INT_MASK) || (widx == SMRL_IDX_STOP);
  wire rd_stat = ar_fire && (ridx == SMRL_IDX_INT_STAT);
  wire recov_ev = in_stop && wake_any;
  wire ready_ev = (state_reg == SMRL_DELAY) && (dly_reg == 8'h01);

  // Read mux; write-only bits read zero
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    if (ridx == SMRL_IDX_CTRL) begin
      rd_mux[SMRL_BIT_FLAG] = flag_reg;
    end else if (ridx == SMRL_IDX_CTRL2) begin
      rd_mux = 32'h0000_0000;
    end else if (ridx == SMRL_IDX_INT_STAT) begin
      rd_mux[1:0] = int_stat_reg;
    end else if (ridx == SMRL_IDX_INT_MASK) begin
      rd_mux[1:0] = int_mask_reg;
    end else if (ridx == SMRL_IDX_STOP) begin
      rd_mux[1:0] = {sys_hold_reset, in_stop};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Sequencer: run, stopped, reset delay
  always_comb begin
    state_next = state_reg;
    dly_next = dly_reg;
    case (state_reg)
      SMRL_RUN: begin
        if (wr_stop) begin
          state_next = SMRL_STOP;
        end else if (ext_rst) begin
          state_next = SMRL_DELAY;
          dly_next = SMRL_DLY_SHORT;
        end
      end
      SMRL_STOP: begin
        // External reset is ignored here on purpose
        if (wake_any) begin
          state_next = SMRL_DELAY;
          dly_next = ctrl_reg[SMRL_BIT_DELAY] ? SMRL_DLY_LONG : SMRL_DLY_SHORT;
        end
      end
      SMRL_DELAY: begin
        dly_next = dly_reg - 8'h01;
        if (dly_reg == 8'h01) begin
          state_next = SMRL_RUN;
        end
      end
      default: begin
        state_next = SMRL_RUN;
        dly_next = 8'h00;
      end
    endcase
  end

  // Pin and reset synchronisers
  always_ff @(posedge aclk) begin
    pin_s1_reg <= pin_raw;
    pin_s2_reg <= pin_s1_reg;
    rst_s1_reg <= ext_reset_n;
    rst_s2_reg <= rst_s1_reg;
  end

  // Sequencer and delay counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= SMRL_RUN;
      dly_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      dly_reg <= dly_next;
    end
  end

  // Flag cleared only by power-on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= 1'b0;
    end else if (recov_ev) begin
      flag_reg <= 1'b1;
    end
  end

  // Control registers; the flag bit is not writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= SMRL_CTRL_RST;
      ctrl2_reg <= SMRL_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wdata_reg & SMRL_CTRL_WMASK;
      end
      if (wr_ctrl2) begin
        ctrl2_reg <= wdata_reg & SMRL_CTRL2_WMASK;
      end
    end
  end

  // Sticky status, clear on read; a new event wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat_reg <= 2'h0;
      int_mask_reg <= 2'h0;
    end else begin
      int_stat_reg <= (rd_stat ? 2'h0 : int_stat_reg) | {ready_ev, recov_ev};
      if (wr_mask) begin
        int_mask_reg <= wdata_reg[1:0];
      end
    end
  end

  // Write channels are taken independently
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      wstrb_reg <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_full_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata[7:0];
        wstrb_reg <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= SMRL_RESP_OK;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= w_hit ? SMRL_RESP_OK : SMRL_RESP_DEC;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read data, captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= SMRL_RESP_OK;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= rd_hit ? SMRL_RESP_OK : SMRL_RESP_DEC;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Outputs
  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign stop_active = in_stop;
  assign osc_restart = in_stop && wake_raw;
  assign sys_hold_reset = (state_reg == SMRL_DELAY);
  assign clk_div16 = ctrl_reg[SMRL_BIT_DIV];
  assign timer_clock_div16 = ctrl_reg[SMRL_BIT_DIV];
  assign irq = |(int_stat_reg & int_mask_reg);

  // Checks
  AST_FLAG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    in_stop && wake_any |=> flag_reg && sys_hold_reset) else $error("flag not set on recovery");
  AST_FLAG_HOLD: assert property (@(posedge aclk)
    flag_reg && aresetn |=> flag_reg || !$past(aresetn)) else $error("flag lost without reset");
  AST_RD_CTRL: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_fire && ridx == SMRL_IDX_CTRL |=> s_axi_rdata[6:0] == 7'h00) else $error("write-only bit read");
  AST_RD_CTRL2: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_fire && ridx == SMRL_IDX_CTRL2 |=> s_axi_rdata == 32'h0000_0000) else $error("second reg readable");
  AST_POR_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
    in_stop && src1 == SMRL_SRC_POR && !wake2 |=> in_stop) else $error("wake with no source");
  AST_DIV: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_ctrl |=> clk_div16 == $past(wdata_reg[0])) else $error("divide bit not applied");
  AST_EITHER: assert property (@(posedge aclk) disable iff (!aresetn)
    in_stop && (wake1 || wake2) |=> !in_stop) else $error("stop not left on event");
  AST_EXT_RST: assert property (@(posedge aclk) disable iff (!aresetn)
    in_stop && ext_rst && !wake_any |=> in_stop) else $error("external reset ended stop");
  AST_DELAY: assert property (@(posedge aclk) disable iff (!aresetn)
    in_stop && wake_any && !ctrl_reg[SMRL_BIT_DELAY] |=> sys_hold_reset [*8]) else $error("delay too short");
  AST_OUT_IGN: assert property (@(posedge aclk) disable iff (!aresetn)
    in_stop && src2 == 3'h1 && !lvl2 && pin_out[0] && (&pin_s2_reg[3:1]) && !pin_s2_reg[0] |=> !in_stop)
    else $error("output pin blocked wake");

endmodule
`default_nettype wire

//--- src/smrl_pkg.sv
// Package of constants and types for the stop mode recovery logic
package smrl_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [5:0] SMRL_IDX_CTRL = 6'h0B;
  localparam logic [5:0] SMRL_IDX_CTRL2 = 6'h0D;
  localparam logic [5:0] SMRL_IDX_INT_STAT = 6'h10;
  localparam logic [5:0] SMRL_IDX_INT_MASK = 6'h11;
  localparam logic [5:0] SMRL_IDX_STOP = 6'h12;
  // Control register fields
  localparam int SMRL_BIT_FLAG = 7;
  localparam int SMRL_BIT_LEVEL = 6;
  localparam int SMRL_BIT_DELAY = 5;
  localparam int SMRL_SRC_LSB = 2;
  localparam int SMRL_BIT_DIV = 0;
  localparam logic [7:0] SMRL_CTRL_RST = 8'h00;
  localparam logic [7:0] SMRL_CTRL_WMASK = 8'h7D;
  localparam logic [7:0] SMRL_CTRL2_WMASK = 8'h5C;
  // Recovery source codes
  localparam logic [2:0] SMRL_SRC_POR = 3'h0;
  localparam logic [2:0] SMRL_SRC_NOR_P3 = 3'h3;
  localparam logic [2:0] SMRL_SRC_NOR_P3P0 = 3'h5;
  // Pin vector: [7:0] port 2, [10:8] port 3 pins 1-3, [11] port 0 pin 0, [12] port 0 pin 7
  localparam int SMRL_NPIN = 13;
  localparam logic [12:0] SMRL_M_P2LO = 13'h000F;
  localparam logic [12:0] SMRL_M_P2 = 13'h00FF;
  localparam logic [12:0] SMRL_M_P3 = 13'h0700;
  localparam logic [12:0] SMRL_M_P3P0 = 13'h1F00;
  localparam logic [12:0] SMRL_M_P3P2 = 13'h0707;
  // Reset delay counts in clock cycles
  localparam logic [7:0] SMRL_DLY_SHORT = 8'h10;
  localparam logic [7:0] SMRL_DLY_LONG = 8'h80;
  // Interrupt status bits
  localparam int SMRL_IRQ_RECOV = 0;
  localparam int SMRL_IRQ_READY = 1;
  // Bus answers
  localparam logic [1:0] SMRL_RESP_OK = 2'h0;
  localparam logic [1:0] SMRL_RESP_DEC = 2'h3;
  // Sequencer states, Gray along run, stop, delay
  typedef enum logic [1:0] {
    SMRL_RUN = 2'b00,
    SMRL_STOP = 2'b01,
    SMRL_DELAY = 2'b11
  } smrl_state_t;
endpackage

//--- tb/smrl_pins_model.sv
// Model of the external wake-up signals on the port pins
`timescale 1ns/10ps
`default_nettype none
module smrl_pins_model (
  input wire logic [12:0] pin_lvl,
  input wire logic [12:0] pin_out,
  output logic [7:0] port2_pins,
  output logic [3:1] port3_pins,
  output logic port0_pin0,
  output logic port0_pin7
);
  logic [12:0] drive;
  // Output pins show the opposite level, so a leak into the term blocks the wake
  assign drive = pin_lvl ^ pin_out;
  assign port2_pins = drive[7:0];
  assign port3_pins = drive[10:8];
  assign port0_pin0 = drive[11];
  assign port0_pin7 = drive[12];
endmodule
`default_nettype wire

//--- tb/tb_smrl_top.sv
// Self-checking testbench for the stop mode recovery logic
`timescale 1ns/10ps
`default_nettype none
module tb_smrl_top;
  import smrl_pkg::*;
  localparam logic [7:0] A_CTRL = {SMRL_IDX_CTRL, 2'b00};
  localparam logic [7:0] A_CTRL2 = {SMRL_IDX_CTRL2, 2'b00};
  localparam logic [7:0] A_STAT = {SMRL_IDX_INT_STAT, 2'b00};
  localparam logic [7:0] A_MASK = {SMRL_IDX_INT_MASK, 2'b00};
  localparam logic [7:0] A_STOP = {SMRL_IDX_STOP, 2'b00};
  localparam int LIMIT = 20000;
  logic aclk = 1'b0, aresetn = 1'b0, ext_reset_n = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [12:0] pin_lvl = 13'h0000, pin_out = 13'h0000;
  logic [7:0] p2;
  logic [3:1] p3;
  logic p00, p07, stop_active, osc_restart, sys_hold_reset, clk_div16, timer_clock_div16, irq;
  int errors = 0, n_checks = 0, cyc = 0;
  always #12.5 aclk = ~aclk;
  smrl_pins_model pins (.pin_lvl(pin_lvl), .pin_out(pin_out), .port2_pins(p2),
    .port3_pins(p3), .port0_pin0(p00), .port0_pin7(p07));
  smrl_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .port2_pins(p2),
    .port3_pins(p3), .port0_pin0(p00), .port0_pin7(p07), .port2_is_out(pin_out[7:0]),
    .port3_is_out(pin_out[10:8]), .port0_is_out(pin_out[11]), .ext_reset_n(ext_reset_n),
    .stop_active(stop_active), .osc_restart(osc_restart), .sys_hold_reset(sys_hold_reset),
    .clk_div16(clk_div16), .timer_clock_div16(timer_clock_div16), .irq(irq));
  // Verdict and end of run, also reached by the hang guard
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // Write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin aw_ok = 1'b1; awvalid <= 1'b0; end
      if (!w_ok && wready === 1'b1) begin w_ok = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  // Read: response and data taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  function automatic logic [12:0] mask_of(input logic [2:0] code);
    case (code)
      3'h1: mask_of = SMRL_M_P2LO;
      3'h2: mask_of = SMRL_M_P2;
      3'h3, 3'h4: mask_of = SMRL_M_P3;
      3'h5, 3'h6: mask_of = SMRL_M_P3P0;
      3'h7: mask_of = SMRL_M_P3P2;
      default: mask_of = 13'h0000;
    endcase
  endfunction
  // One stop and recovery; idle pins hold the term away from the wanted level, inverted pins bring it to that level
  task automatic run_case(input logic prim, input logic [2:0] code, input logic lvl, input logic dly,
      input logic [12:0] outs, input logic [1:0] msk);
    logic [7:0] v;
    int n;
    v = {1'b0, lvl, dly, code, 2'b00};
    pin_lvl <= lvl ? mask_of(code) : ~mask_of(code);
    pin_out <= outs;
    wr(A_CTRL, prim ? {24'h0, v | 8'h01} : 32'h0, SMRL_RESP_OK);
    wr(A_CTRL2, prim ? 32'h0 : {24'h0, v & 8'h5C}, SMRL_RESP_OK);
    wr(A_MASK, {30'h0, msk}, SMRL_RESP_OK);
    wr(A_STOP, 32'h1, SMRL_RESP_OK);
    ext_reset_n <= 1'b0;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    chk({28'h0, stop_active, clk_div16, timer_clock_div16, osc_restart}, {28'h0, 1'b1, prim, prim, 1'b0});
    @(posedge aclk);
    ext_reset_n <= 1'b1;
    repeat (4) @(posedge aclk);
    pin_lvl <= ~pin_lvl;
    @(negedge aclk);
    chk({30'h0, stop_active, osc_restart}, 32'h3);
    n = 0;
    while (stop_active !== 1'b0 && n < 8) begin @(negedge aclk); n++; end
    chk({31'h0, sys_hold_reset}, 32'h1);
    n = 0;
    while (sys_hold_reset === 1'b1 && n < 200) begin @(negedge aclk); n++; end
    chk(32'(n), {24'h0, dly ? SMRL_DLY_LONG : SMRL_DLY_SHORT});
    chk({31'h0, irq}, {31'h0, msk != 2'h0});
    rd(A_STAT, 32'h3, SMRL_RESP_OK);
    rd(A_STAT, 32'h0, SMRL_RESP_OK);
    @(negedge aclk);
    chk({31'h0, irq}, 32'h0);
    rd(A_CTRL, 32'h80, SMRL_RESP_OK);
  endtask
  // Hang guard on total clock cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      errors++;
      close_out();
    end
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_CTRL, 32'h0, SMRL_RESP_OK);
    rd(A_CTRL2, 32'h0, SMRL_RESP_OK);
    rd(A_STOP, 32'h0, SMRL_RESP_OK);
    // External reset in run does start a hold, unlike in stop
    ext_reset_n <= 1'b0;
    repeat (4) @(posedge aclk);
    ext_reset_n <= 1'b1;
    @(negedge aclk);
    chk({31'h0, sys_hold_reset}, 32'h1);
    repeat (20) @(posedge aclk);
    rd(A_STAT, 32'h2, SMRL_RESP_OK);
    wr(A_CTRL, 32'hFF, SMRL_RESP_OK);
    rd(A_CTRL, 32'h0, SMRL_RESP_OK);
    wr(8'hF0, 32'h1, SMRL_RESP_DEC);
    rd(8'hF0, 32'h0, SMRL_RESP_DEC);
    for (int c = 1; c < 8; c++) run_case(1'b0, 3'(c), 1'b0, 1'b0, 13'h0000, 2'h3);
    run_case(1'b0, 3'h1, 1'b0, 1'b0, 13'h0001, 2'h3);
    run_case(1'b1, 3'h4, 1'b1, 1'b1, 13'h0000, 2'h0);
    wr(A_CTRL, 32'h0, SMRL_RESP_OK);
    rd(A_CTRL, 32'h80, SMRL_RESP_OK);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_CTRL, 32'h0, SMRL_RESP_OK);
    close_out();
  end
endmodule
`default_nettype wire
